// [hw/omc_mode_ctrl.sv]
// Operating mode, password, beeper and memory clear controller.
`timescale 1ns/1ps

module omc_mode_ctrl
  import omc_pkg::*;
#(
  parameter int AW = 16,
  parameter int PROG_WORDS = 32768,
  parameter int AREA_WORDS = 4096
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Pins from outside the clock domain.
  input wire logic console_attached_in,
  input wire logic other_periph_in,
  input wire logic [1:0] mode_switch_in,
  input wire logic start_in,
  input wire logic write_enable_in,
  input wire logic lang_switch_in,
  input wire logic eprom_unit_in,
  // Console keys and error events from same-clock logic.
  input wire logic key_valid_in,
  input wire logic [4:0] key_code_in,
  input wire logic op_error_in,
  // Register port.
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Mode and permission outputs.
  output logic [1:0] mode_out,
  output logic run_out,
  output logic write_allow_out,
  output logic force_allow_out,
  output logic pw_prompt_out,
  // Console display and beeper.
  output logic buzzer_indicator_out,
  output logic beep_out,
  output logic lang_jp_out,
  output logic display_clear_out,
  output logic [5:0] clear_list_out,
  // Memory clear write port.
  output logic clear_busy_out,
  output logic clear_we_out,
  output logic [2:0] clear_area_out,
  output logic [AW-1:0] clear_addr_out
);

  // Refuse sizes that the address counter cannot hold.
  if (AW > ADDR_ENTRY_W || PROG_WORDS > (1 << AW) || AREA_WORDS > (1 << AW)
      || PROG_WORDS < 1 || AREA_WORDS < 1) begin : g_bad_size
    $error("omc_mode_ctrl: area sizes do not fit the address width");
  end

  localparam logic [ADDR_ENTRY_W-1:0] PROG_LIMIT = ADDR_ENTRY_W'(PROG_WORDS);
  localparam logic [ADDR_ENTRY_W-1:0] AREA_LIMIT = ADDR_ENTRY_W'(AREA_WORDS);

  // Two-flop synchroniser for all pins; only the second stage is read.
  logic [7:0] pin_meta_q;
  logic [7:0] pin_sync_q;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pin_meta_q <= 8'h00;
      pin_sync_q <= 8'h00;
    end else begin
      pin_meta_q <= {console_attached_in, other_periph_in, mode_switch_in, start_in,
                     write_enable_in, lang_switch_in, eprom_unit_in};
      pin_sync_q <= pin_meta_q;
    end
  end

  logic console_s;
  logic other_s;
  logic [1:0] switch_s;
  logic start_s;
  logic we_s;
  logic lang_s;
  logic eprom_s;
  assign {console_s, other_s, switch_s, start_s, we_s, lang_s, eprom_s} = pin_sync_q;

  // Registered state.
  omc_state_t state_q;
  omc_mode_t mode_q;
  logic [1:0] pu_cnt_q;
  logic pu_done_q;
  logic console_prev_q;
  logic win_q;
  logic alt_pend_q;
  logic beep_en_q;
  logic keep_hold_q;
  logic keep_cnt_q;
  logic keep_data_q;
  logic [ADDR_ENTRY_W-1:0] start_q;
  logic [2:0] digits_q;
  logic [2:0] cl_area_q;
  logic [ADDR_ENTRY_W-1:0] cl_addr_q;

  // Decoded events.
  logic unlocked;
  logic pw_accept;
  logic sw_legal;
  logic sw_change;
  logic pu_fire;
  logic attach_rise;
  logic is_digit;
  logic cmd_wr;
  logic [5:0] list;
  logic [ADDR_ENTRY_W-1:0] limit;
  logic area_end;
  logic clr_last;
  logic [20:0] acc_next;
  logic [AREA_COUNT-1:0] area_onehot;

  assign unlocked = (state_q == ST_IDLE) || (state_q == ST_SELECT) || (state_q == ST_CLEARING);
  assign pw_accept = (state_q == ST_PW_CLEAR) && key_valid_in && (key_code_in == KEY_WATCH);
  assign sw_legal = (switch_s != 2'h3);
  // A console that has only just come back must not move the mode before it relocks.
  assign sw_change = unlocked && console_s && console_prev_q && sw_legal && (switch_s != mode_q);
  assign pu_fire = !pu_done_q && (pu_cnt_q == PU_SETTLE_CYCLES);
  assign attach_rise = pu_done_q && console_s && !console_prev_q;
  assign is_digit = key_code_in < KEY_DIGIT_LIMIT;
  assign cmd_wr = reg_wr_in && (reg_addr_in == REG_CMD);
  assign acc_next = {4'h0, start_q} * 21'd10 + {17'h0_0000, key_code_in[3:0]};

  // Areas to clear: retaining holding words keeps support bits too. see RL16 see RL19 see RL20
  assign list[AREA_PROG] = we_s && !eprom_s; // see RL17
  assign list[AREA_IO] = 1'b1;
  assign list[AREA_HOLD] = !keep_hold_q;
  assign list[AREA_SUPPORT] = !keep_hold_q;
  assign list[AREA_DATA] = !keep_data_q;
  assign list[AREA_TIMER] = !keep_cnt_q;

  // Clear engine step decode.
  assign area_onehot = 6'h01 << cl_area_q;
  assign limit = (cl_area_q == AREA_PROG) ? PROG_LIMIT : AREA_LIMIT;
  assign area_end = ((list & area_onehot) == 6'h00) || (cl_addr_q >= limit - 17'h0_0001);
  assign clr_last = (state_q == ST_CLEARING) && (cl_area_q == AREA_TIMER) && area_end;

  // Power-up: wait for the synchronisers to settle before sampling attachments.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pu_cnt_q <= 2'h0;
      pu_done_q <= 1'b0;
      console_prev_q <= 1'b0;
    end else begin
      if (!pu_done_q) begin
        pu_cnt_q <= pu_cnt_q + 2'h1;
      end
      if (pu_fire) begin
        pu_done_q <= 1'b1;
      end
      console_prev_q <= console_s;
    end
  end

  // Mode register: moves only on power-up, password or accepted switch change. see RL23
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mode_q <= MODE_EDIT;
    end else if (pu_fire) begin
      if (console_s) begin
        mode_q <= sw_legal ? omc_mode_t'(switch_s) : MODE_EDIT; // see RL6
      end else if (other_s) begin
        mode_q <= MODE_EDIT; // see RL7
      end else begin
        mode_q <= MODE_EXECUTE; // see RL5
      end
    end else if (pw_accept && console_s && sw_legal && !attach_rise) begin
      mode_q <= omc_mode_t'(switch_s); // see RL12
    end else if (sw_change) begin
      mode_q <= omc_mode_t'(switch_s); // see RL9
    end
  end

  // Console command state, retention choices, start address and beeper setting.
  // Attachment edges only relock the console; mode is left alone. see RL8 see RL10
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_q <= ST_LOCKED; // see RL11
      win_q <= 1'b0;
      alt_pend_q <= 1'b0;
      beep_en_q <= BEEP_EN_RST;
      keep_hold_q <= 1'b0;
      keep_cnt_q <= 1'b0;
      keep_data_q <= 1'b0;
      start_q <= '0;
      digits_q <= 3'h0;
    end else if (attach_rise) begin
      state_q <= ST_LOCKED; // see RL11
      win_q <= 1'b0;
      alt_pend_q <= 1'b0;
    end else begin
      if (sw_change) begin
        win_q <= 1'b1; // see RL13
        alt_pend_q <= 1'b0;
      end
      if (reg_wr_in && (reg_addr_in == REG_CLR_CFG) && state_q != ST_CLEARING) begin
        keep_hold_q <= reg_wdata_in[CFG_KEEP_HOLD];
        keep_cnt_q <= reg_wdata_in[CFG_KEEP_CNT];
        keep_data_q <= reg_wdata_in[CFG_KEEP_DATA];
        start_q <= reg_wdata_in[CFG_START_LSB +: ADDR_ENTRY_W];
      end
      unique case (state_q)
        ST_LOCKED: begin
          if (key_valid_in && key_code_in == KEY_CLEAR) begin
            state_q <= ST_PW_CLEAR; // see RL11
          end
        end
        ST_PW_CLEAR: begin
          if (pw_accept) begin
            state_q <= ST_IDLE;
            win_q <= 1'b1; // see RL13
          end else if (key_valid_in && key_code_in != KEY_CLEAR) begin
            state_q <= ST_LOCKED;
          end
        end
        ST_IDLE: begin
          if (key_valid_in) begin
            win_q <= 1'b0;
            alt_pend_q <= 1'b0;
            if (key_code_in == KEY_ALT && win_q) begin
              win_q <= 1'b1;
              alt_pend_q <= 1'b1;
            end else if (key_code_in == KEY_DIGIT_1 && alt_pend_q) begin
              beep_en_q <= !beep_en_q; // see RL13
            end else if (key_code_in == KEY_RETAIN && mode_q == MODE_EDIT) begin
              state_q <= ST_SELECT;
              keep_hold_q <= 1'b0;
              keep_cnt_q <= 1'b0;
              keep_data_q <= 1'b0;
              start_q <= '0;
              digits_q <= 3'h0;
            end else if (key_code_in == KEY_WRITE && mode_q == MODE_EDIT) begin
              state_q <= ST_CLEARING; // see RL18
            end
          end else if (cmd_wr && reg_wdata_in[CMD_START] && mode_q == MODE_EDIT) begin
            state_q <= ST_CLEARING; // see RL18
          end
        end
        ST_SELECT: begin
          if (mode_q != MODE_EDIT) begin
            state_q <= ST_IDLE;
          end else if (key_valid_in) begin
            if (key_code_in == KEY_HOLD) begin
              keep_hold_q <= 1'b1; // see RL19
            end else if (key_code_in == KEY_COUNTER) begin
              keep_cnt_q <= 1'b1; // see RL20
            end else if (key_code_in == KEY_DATA) begin
              keep_data_q <= 1'b1;
            end else if (is_digit && digits_q < 3'(ADDR_DIGITS)) begin
              start_q <= acc_next[ADDR_ENTRY_W-1:0]; // see RL21
              digits_q <= digits_q + 3'h1;
            end else if (key_code_in == KEY_WRITE) begin
              state_q <= ST_CLEARING;
            end else if (key_code_in == KEY_CLEAR) begin
              // Each press backs out one level, so two may be needed. see RL22
              if (digits_q != 3'h0) begin
                start_q <= '0;
                digits_q <= 3'h0;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
        end
        ST_CLEARING: begin
          // Leaving edit mode or a cancel stops the clear at once. see RL18 see RL22
          if (mode_q != MODE_EDIT || clr_last || (cmd_wr && reg_wdata_in[CMD_CANCEL])
              || (key_valid_in && key_code_in == KEY_CLEAR)) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Clear engine walks each listed area; program area starts at the typed address.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cl_area_q <= AREA_PROG;
      cl_addr_q <= '0;
    end else if (state_q != ST_CLEARING) begin
      cl_area_q <= AREA_PROG;
      cl_addr_q <= start_q; // see RL21
    end else if (area_end) begin
      if (cl_area_q != AREA_TIMER) begin
        cl_area_q <= cl_area_q + 3'h1;
      end
      cl_addr_q <= '0;
    end else begin
      cl_addr_q <= cl_addr_q + 17'h0_0001;
    end
  end

  // Clear write port; a start address past the end writes nothing.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      clear_we_out <= 1'b0;
      clear_area_out <= AREA_PROG;
      clear_addr_out <= '0;
      clear_busy_out <= 1'b0;
      clear_list_out <= 6'h3F;
    end else begin
      clear_we_out <= (state_q == ST_CLEARING) && (mode_q == MODE_EDIT)
                      && ((list & area_onehot) != 6'h00) && (cl_addr_q < limit);
      clear_area_out <= cl_area_q;
      clear_addr_out <= cl_addr_q[AW-1:0];
      clear_busy_out <= (state_q == ST_CLEARING);
      clear_list_out <= list; // see RL20
    end
  end

  // Mode-driven permissions; run also waits for power-up to finish.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mode_out <= MODE_EDIT;
      run_out <= 1'b0;
      write_allow_out <= 1'b0;
      force_allow_out <= 1'b0;
      pw_prompt_out <= 1'b0;
    end else begin
      mode_out <= mode_q;
      run_out <= pu_done_q && (mode_q != MODE_EDIT) && start_s; // see RL1 see RL4
      write_allow_out <= unlocked && (mode_q != MODE_EXECUTE); // see RL2
      force_allow_out <= unlocked && (mode_q == MODE_OBSERVE); // see RL3
      pw_prompt_out <= pu_done_q && !unlocked; // see RL11
    end
  end

  // Beeper, language and display; errors beep whatever the key setting. see RL14
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      beep_out <= 1'b0;
      buzzer_indicator_out <= BEEP_EN_RST;
      lang_jp_out <= 1'b0;
      display_clear_out <= 1'b0;
    end else begin
      beep_out <= op_error_in || (key_valid_in && beep_en_q);
      buzzer_indicator_out <= beep_en_q; // see RL13
      lang_jp_out <= lang_s; // see RL15
      display_clear_out <= key_valid_in && (key_code_in == KEY_CLEAR); // see RL22
    end
  end

  // Register reads answer one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (reg_rd_in) begin
      reg_rdata_out <= 32'h0000_0000;
      if (reg_addr_in == REG_STATUS) begin
        reg_rdata_out[ST_MODE_LSB +: 2] <= mode_q;
        reg_rdata_out[ST_UNLOCKED] <= unlocked;
        reg_rdata_out[ST_RUN] <= run_out;
        reg_rdata_out[ST_BEEP_EN] <= beep_en_q;
        reg_rdata_out[ST_BUSY] <= (state_q == ST_CLEARING);
        reg_rdata_out[ST_LANG] <= lang_s;
        reg_rdata_out[ST_PROMPT] <= pu_done_q && !unlocked;
        reg_rdata_out[ST_LIST_LSB +: 6] <= list;
        reg_rdata_out[ST_CONSOLE] <= console_s;
      end else if (reg_addr_in == REG_CLR_CFG) begin
        reg_rdata_out[CFG_KEEP_HOLD] <= keep_hold_q;
        reg_rdata_out[CFG_KEEP_CNT] <= keep_cnt_q;
        reg_rdata_out[CFG_KEEP_DATA] <= keep_data_q;
        reg_rdata_out[CFG_START_LSB +: ADDR_ENTRY_W] <= start_q;
      end
    end
  end

  // Checks on the design's own behaviour.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_run_gate;
    run_out |-> $past(start_s) && $past(mode_q) != MODE_EDIT;
  endproperty
  a_run_gate: assert property (p_run_gate) else $error("run without start or in edit"); // see RL1

  property p_exec_no_write;
    (mode_q == MODE_EXECUTE) |=> !write_allow_out;
  endproperty
  a_exec_no_write: assert property (p_exec_no_write) else $error("write allowed in execute"); // see RL2

  property p_observe_force;
    (unlocked && mode_q == MODE_OBSERVE) |=> force_allow_out && write_allow_out;
  endproperty
  a_observe_force: assert property (p_observe_force) else $error("observe mode lacks forcing"); // see RL3

  property p_pu_empty;
    (pu_fire && !console_s && !other_s) |=> mode_q == MODE_EXECUTE;
  endproperty
  a_pu_empty: assert property (p_pu_empty) else $error("bare power-up not execute"); // see RL5

  property p_pu_other;
    (pu_fire && !console_s && other_s) |=> mode_q == MODE_EDIT;
  endproperty
  a_pu_other: assert property (p_pu_other) else $error("peripheral power-up not edit"); // see RL7

  property p_attach_keeps;
    (pu_done_q && console_s != console_prev_q) |=> $stable(mode_q);
  endproperty
  a_attach_keeps: assert property (p_attach_keeps) else $error("attach or detach moved mode"); // see RL8

  property p_locked_mode;
    (pu_done_q && !unlocked && !pw_accept) |=> $stable(mode_q);
  endproperty
  a_locked_mode: assert property (p_locked_mode) else $error("mode moved while locked"); // see RL9

  property p_pw_adopt;
    (pw_accept && console_s && sw_legal && !attach_rise) |=> ##0 mode_q == $past(switch_s)
      ##1 mode_out == $past(switch_s, 2);
  endproperty
  a_pw_adopt: assert property (p_pw_adopt) else $error("password did not adopt switch"); // see RL12

  property p_error_beep;
    op_error_in |=> beep_out;
  endproperty
  a_error_beep: assert property (p_error_beep) else $error("error without beep"); // see RL14

  property p_prog_protect;
    (clear_we_out && clear_area_out == AREA_PROG) |-> $past(we_s && !eprom_s, 2);
  endproperty
  a_prog_protect: assert property (p_prog_protect) else $error("protected program cleared"); // see RL17

  property p_clear_edit;
    clear_we_out |-> $past(mode_q) == MODE_EDIT;
  endproperty
  a_clear_edit: assert property (p_clear_edit) else $error("clear outside edit mode"); // see RL18

  property p_partial;
    (clear_we_out && clear_area_out == AREA_PROG) |-> {1'b0, clear_addr_out} >= start_q;
  endproperty
  a_partial: assert property (p_partial) else $error("program cleared below start"); // see RL21

  property p_cancel;
    (state_q == ST_CLEARING && key_valid_in && key_code_in == KEY_CLEAR && !attach_rise)
      |=> state_q == ST_IDLE ##1 !clear_busy_out;
  endproperty
  a_cancel: assert property (p_cancel) else $error("clear key did not cancel"); // see RL22

  c_pu_console: cover property (pu_fire && console_s && sw_legal);
  c_beep_toggle: cover property (state_q == ST_IDLE && alt_pend_q && key_valid_in
                                 && key_code_in == KEY_DIGIT_1);
  c_partial_clear: cover property (clear_we_out && clear_area_out == AREA_PROG
                                   && start_q != '0);
  c_full_done: cover property (clr_last);

endmodule

// [pkg/omc_pkg.sv]
// Package with the constants, codes and types of the mode and memory clear controller.
// What this block does
// RL1: Execute mode runs program only while start asserted.
// RL2: Execute mode allows monitoring, refuses memory writes.
// RL3: Observe mode runs I/O, allows forcing and values.
// RL4: Edit mode never executes the program.
// RL5: Power-up with nothing attached enters execute mode.
// RL6: Power-up with console attached adopts switch mode.
// RL7: Power-up with other peripheral enters edit mode.
// RL8: Attaching peripheral while powered keeps current mode.
// RL9: Mode switch changes accepted only after password.
// RL10: Detaching peripheral keeps the current mode.
// RL11: Password prompt at power-on or attach: clear, watch.
// RL12: Accepted password adopts the switch-selected mode.
// RL13: Alternate then 1 toggles key beeper after unlock.
// RL14: Operational errors always sound the beeper.
// RL15: Language switch off English, on Japanese.
// RL16: Default clear erases program and all data areas.
// RL17: Write-protect or EPROM keeps program memory uncleared.
// RL18: Memory clear accepted only in edit mode.
// RL19: Retaining holding words also retains support bits.
// RL20: Counter key retains timer words; display lists areas.
// RL21: Partial program clear starts at given address.
// RL22: Clear key cancels operation and clears display.
// RL23: Mode is a registered three-valued state.
package omc_pkg;

  // Operating modes; the console mode switch uses the same coding.
  typedef enum logic [1:0] {
    MODE_EXECUTE = 2'h0,
    MODE_OBSERVE = 2'h1,
    MODE_EDIT = 2'h2
  } omc_mode_t;

  // Console command state.
  typedef enum logic [2:0] {
    ST_LOCKED = 3'h0,
    ST_PW_CLEAR = 3'h1,
    ST_IDLE = 3'h2,
    ST_SELECT = 3'h3,
    ST_CLEARING = 3'h4
  } omc_state_t;

  // Console key codes; codes 0 to 9 are the digit keys.
  localparam logic [4:0] KEY_CLEAR = 5'h0A;
  localparam logic [4:0] KEY_WATCH = 5'h0B;
  localparam logic [4:0] KEY_ALT = 5'h0C;
  localparam logic [4:0] KEY_RETAIN = 5'h0D;
  localparam logic [4:0] KEY_HOLD = 5'h0E;
  localparam logic [4:0] KEY_COUNTER = 5'h0F;
  localparam logic [4:0] KEY_DATA = 5'h10;
  localparam logic [4:0] KEY_WRITE = 5'h11;
  localparam logic [4:0] KEY_DIGIT_1 = 5'h01;
  localparam logic [4:0] KEY_DIGIT_LIMIT = 5'h0A;

  // Memory areas in clearing order.
  localparam logic [2:0] AREA_PROG = 3'h0;
  localparam logic [2:0] AREA_IO = 3'h1;
  localparam logic [2:0] AREA_HOLD = 3'h2;
  localparam logic [2:0] AREA_SUPPORT = 3'h3;
  localparam logic [2:0] AREA_DATA = 3'h4;
  localparam logic [2:0] AREA_TIMER = 3'h5;
  localparam int AREA_COUNT = 6;

  // Register byte offsets.
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CLR_CFG = 8'h04;
  localparam logic [7:0] REG_CMD = 8'h08;

  // Field positions in the clear configuration and command registers.
  localparam int CFG_KEEP_HOLD = 0;
  localparam int CFG_KEEP_CNT = 1;
  localparam int CFG_KEEP_DATA = 2;
  localparam int CFG_START_LSB = 8;
  localparam int CMD_START = 0;
  localparam int CMD_CANCEL = 1;

  // Field positions in the status register.
  localparam int ST_MODE_LSB = 0;
  localparam int ST_UNLOCKED = 2;
  localparam int ST_RUN = 3;
  localparam int ST_BEEP_EN = 4;
  localparam int ST_BUSY = 5;
  localparam int ST_LANG = 6;
  localparam int ST_PROMPT = 7;
  localparam int ST_LIST_LSB = 8;
  localparam int ST_CONSOLE = 16;

  // Width of the typed start address (five decimal digits).
  localparam int ADDR_ENTRY_W = 17;
  localparam int ADDR_DIGITS = 5;

  // Values after reset and settling counts.
  localparam logic BEEP_EN_RST = 1'b1;
  localparam logic [1:0] PU_SETTLE_CYCLES = 2'h3;

endpackage

// [verification/omc_console_model.sv]
// Behavioural model of the handheld console: attach pin, mode switch and keys.
`timescale 1ns/1ps
module omc_console_model
  import omc_pkg::*;
(
  // Clock.
  input wire logic clk_in,
  // Console pins and key stream.
  output logic attached_out,
  output logic [1:0] switch_out,
  output logic key_valid_out,
  output logic [4:0] key_code_out
);
  // Idle code differs from any key just sent, so a stale code never looks valid.
  initial begin
    attached_out = 1'b0;
    switch_out = MODE_EDIT;
    key_valid_out = 1'b0;
    key_code_out = 5'h1F;
  end
  // Pins move just after an edge, like a hand on the cable and switch.
  task automatic set(input logic att, input logic [1:0] sw);
    @(posedge clk_in);
    attached_out <= att;
    switch_out <= sw;
  endtask
  // One key is a single-cycle strobe; a gap cycle follows each key.
  task automatic press(input logic [4:0] code);
    @(posedge clk_in);
    key_valid_out <= 1'b1;
    key_code_out <= code;
    @(posedge clk_in);
    key_valid_out <= 1'b0;
    key_code_out <= ~code;
  endtask
  // Access code is clear followed by watch.
  task automatic unlock();
    press(KEY_CLEAR);
    press(KEY_WATCH);
  endtask
endmodule

// [verification/tb_top.sv]
// Self-checking bench for the mode and memory clear controller.
`timescale 1ns/1ps
module tb_top;
  import omc_pkg::*;
  localparam int PW = 16;
  localparam int WW = 8;
  logic clk_in = 1'b0, rst_n_in = 1'b0, other_periph_in = 1'b0, start_in = 1'b1;
  logic write_enable_in = 1'b1, lang_switch_in = 1'b0, eprom_unit_in = 1'b0;
  logic op_error_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0000_0000;
  logic console_attached_in, key_valid_in, run_out, write_allow_out, force_allow_out;
  logic pw_prompt_out, buzzer_indicator_out, beep_out, lang_jp_out, clear_busy_out;
  logic clear_we_out, display_clear_out;
  logic [1:0] mode_switch_in, mode_out;
  logic [4:0] key_code_in;
  logic [31:0] reg_rdata_out, rd;
  logic [5:0] clear_list_out;
  logic [2:0] clear_area_out;
  logic [15:0] clear_addr_out;
  int bad_count = 0, comparisons = 0, cycles = 0, beeps = 0;
  int wr_cnt[6];
  // Clock of 100 ns period.
  always #50 clk_in = ~clk_in;
  omc_console_model i_omc_console_model (.clk_in(clk_in), .attached_out(console_attached_in),
    .switch_out(mode_switch_in), .key_valid_out(key_valid_in), .key_code_out(key_code_in));
  omc_mode_ctrl #(.AW(16), .PROG_WORDS(PW), .AREA_WORDS(WW)) i_omc_mode_ctrl (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .console_attached_in(console_attached_in),
    .other_periph_in(other_periph_in), .mode_switch_in(mode_switch_in), .start_in(start_in),
    .write_enable_in(write_enable_in), .lang_switch_in(lang_switch_in),
    .eprom_unit_in(eprom_unit_in), .key_valid_in(key_valid_in), .key_code_in(key_code_in),
    .op_error_in(op_error_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .mode_out(mode_out), .run_out(run_out), .write_allow_out(write_allow_out),
    .force_allow_out(force_allow_out), .pw_prompt_out(pw_prompt_out),
    .buzzer_indicator_out(buzzer_indicator_out), .beep_out(beep_out),
    .lang_jp_out(lang_jp_out), .display_clear_out(display_clear_out),
    .clear_list_out(clear_list_out),
    .clear_busy_out(clear_busy_out), .clear_we_out(clear_we_out),
    .clear_area_out(clear_area_out), .clear_addr_out(clear_addr_out));
  // Reference counts of clear writes per area and of beeps; also the hang limit.
  always @(posedge clk_in) begin
    cycles++;
    if (clear_we_out === 1'b1 && clear_area_out < 3'h6) wr_cnt[clear_area_out]++;
    if (beep_out === 1'b1) beeps++;
    if (cycles == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (bad_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Power cycle: reset values are checked before the power-up decision lands.
  task automatic power_up(input logic cons, input logic oth, input logic [1:0] sw);
    rst_n_in <= 1'b0;
    other_periph_in <= oth;
    i_omc_console_model.set(cons, sw);
    tick(15);
    chk({mode_out, buzzer_indicator_out, clear_list_out}, {MODE_EDIT, 7'h7F});
    rst_n_in <= 1'b1;
    tick(10);
  endtask
  // Read data appear in the cycle after the strobe and hold until the next read; sample just there.
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
    @(posedge clk_in);
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  // Starts a clear from the console and compares each area's word count.
  task automatic do_clear(input int p, io, h, s, d, t);
    int exp[6];
    exp = '{p, io, h, s, d, t};
    wr_cnt = '{default: 0};
    i_omc_console_model.press(KEY_WRITE);
    tick(3);
    for (int i = 0; i < 400 && clear_busy_out !== 1'b0; i++) tick(1);
    for (int i = 0; i < 6; i++) chk(wr_cnt[i], exp[i]);
  endtask
  // Main sequence: three power-ups, then password, beeper and clears.
  initial begin
    void'($urandom(2));
    power_up(1'b0, 1'b0, MODE_EDIT);
    chk(mode_out, MODE_EXECUTE);
    chk(write_allow_out, 1'b0);
    reg_read(REG_STATUS, rd);
    chk(rd[1:0], MODE_EXECUTE);
    reg_read(8'hFC, rd);
    chk(rd, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      start_in <= 1'($urandom);
      lang_switch_in <= 1'($urandom);
      tick(6);
      chk(run_out, start_in);
      chk(lang_jp_out, lang_switch_in);
    end
    start_in <= 1'b1;
    power_up(1'b1, 1'b0, MODE_OBSERVE);
    chk(mode_out, MODE_OBSERVE);
    power_up(1'b0, 1'b1, MODE_OBSERVE);
    chk(mode_out, MODE_EDIT);
    i_omc_console_model.set(1'b1, MODE_OBSERVE);
    tick(8);
    chk(mode_out, MODE_EDIT);
    chk(pw_prompt_out, 1'b1);
    other_periph_in <= 1'b0;
    tick(8);
    chk(mode_out, MODE_EDIT);
    chk(run_out, 1'b0);
    i_omc_console_model.unlock();
    tick(8);
    chk(pw_prompt_out, 1'b0);
    chk(mode_out, MODE_OBSERVE);
    chk({force_allow_out, run_out}, 2'b11);
    i_omc_console_model.press(KEY_ALT);
    i_omc_console_model.press(KEY_DIGIT_1);
    tick(2);
    chk(buzzer_indicator_out, 1'b0);
    beeps = 0;
    op_error_in <= 1'b1;
    tick(1);
    op_error_in <= 1'b0;
    tick(3);
    chk(beeps, 1);
    do_clear(0, 0, 0, 0, 0, 0);
    i_omc_console_model.set(1'b1, MODE_EDIT);
    tick(8);
    chk({mode_out, run_out}, {MODE_EDIT, 1'b0});
    do_clear(PW, WW, WW, WW, WW, WW);
    i_omc_console_model.press(KEY_RETAIN);
    i_omc_console_model.press(KEY_HOLD);
    i_omc_console_model.press(KEY_COUNTER);
    // Start address 00010, most significant digit first.
    for (int i = 0; i < 5; i++) i_omc_console_model.press(i == 3 ? 5'h01 : 5'h00);
    tick(2);
    chk(clear_list_out, 6'h13);
    do_clear(PW - 10, WW, 0, 0, WW, 0);
    write_enable_in <= 1'b0;
    reg_write(REG_CLR_CFG, 32'h0000_0004);
    reg_read(REG_CLR_CFG, rd);
    chk(rd, 32'h0000_0004);
    do_clear(0, WW, WW, WW, 0, WW);
    // The clear-display pulse stands only in the cycle after the key.
    i_omc_console_model.press(KEY_CLEAR);
    #1 chk(display_clear_out, 1'b1);
    give_verdict();
  end
endmodule
